// File: core/rpr_cell.sv
`timescale 1ns/100ps
// ==========================================================================
// One output cell: two registers with a normal load path and a force path.
// ==========================================================================
module rpr_cell
    import rpr_pkg::*;
(
    input  wire logic       clk_i,       // System clock.
    input  wire logic       rst_i,       // Synchronous reset, active high.
    input  wire logic       ce_i,        // Clock enable, freezes all state.
    input  wire logic       load_en_i,   // Low while power-up reset runs.
    input  wire logic       preload_i,   // Elevated mode level is present.
    input  wire logic       select_i,    // Picks the register to force.
    input  wire logic       io_pin_i,    // Level seen on the cell's I/O pin.
    input  wire logic [1:0] strobe_i,    // Clock-term pulses, one per reg.
    input  wire logic [1:0] sum_term_i,  // Normal sum-term data per reg.
    output logic      [1:0] q_o          // Register contents.
);

    // ======================================================================
    // Register state.
    // ======================================================================
    logic [1:0] q_reg;   // The two registers of the cell.
    logic [1:0] q_next;  // Their next values.

    // Next-value logic. In force mode any clock-term pulse of the cell
    // writes the pin level into the selected register only; the pin level
    // is taken as is, so output polarity never inverts it.
    always_comb begin
        q_next = q_reg;
        if (load_en_i) begin
            if (preload_i) begin
                if (|strobe_i) begin
                    q_next[select_i] = io_pin_i;
                end
            end else begin
                // Without the mode level only sum terms reach the regs.
                for (int k = 0; k < REGS_PER_CELL; k++) begin
                    if (strobe_i[k]) begin
                        q_next[k] = sum_term_i[k];
                    end
                end
            end
        end
    end

    // Registering only; reset clears both registers low.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= {REGS_PER_CELL{REG_RESET_VAL}};
        end else if (ce_i) begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;

endmodule

// File: core/rpr_pkg.sv
// ==========================================================================
// Shared constants for the register preload and power-up reset block.
// ==========================================================================
package rpr_pkg;

    // Number of output cells; each cell holds two registers.
    localparam int NUM_CELLS_DEF = 10;

    // Registers per cell and the index of each register within a cell.
    localparam int REGS_PER_CELL = 2;
    localparam int REG_FIRST     = 0;
    localparam int REG_SECOND    = 1;

    // System clock period in nanoseconds (20 MHz).
    localparam int CLK_PERIOD_NS = 50;

    // Power-up reset interval, typical and longest, in nanoseconds.
    localparam int PR_TYP_NS = 600;
    localparam int PR_MAX_NS = 1000;

    // Longest time rounds down to whole cycles, never below one.
    localparam int PR_CYCLES_RAW = PR_MAX_NS / CLK_PERIOD_NS;
    localparam int PR_CYCLES     = (PR_CYCLES_RAW < 1) ? 1 : PR_CYCLES_RAW;

    // Width of the reset interval counter.
    localparam int PR_CNT_W = $clog2(PR_CYCLES + 1);

    // Reset value of every register, and of the registered output pins.
    localparam logic REG_RESET_VAL = 1'h0;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        ST_RESETTING = 2'h1,
        ST_RUN       = 2'h2
    } rpr_state_t;

endpackage

// File: core/rpr_preload_top.sv
`timescale 1ns/100ps
// What this block does
// - Test logic forces any register high or low.
// - Pin high loads one, low loads zero.
// - Select low picks first, high second register.
// - Power-up reset clears every register low.
// ==========================================================================
// Register preload and power-up reset for a bank of output cells.
// ==========================================================================
module rpr_preload_top
    import rpr_pkg::*;
#(
    parameter int NUM_CELLS = NUM_CELLS_DEF  // Output cells in the bank.
)
(
    input  wire logic                   SYS_CLK_I,      // 20 MHz clock.
    input  wire logic                   SYS_RST_I,      // Power-up reset.
    input  wire logic                   SYS_CE_I,       // Clock enable.
    input  wire logic                   PRELOAD_HV_I,   // Mode level seen.
    input  wire logic                   SELECT_I,       // Register select.
    input  wire logic [NUM_CELLS-1:0]   IO_PIN_I,       // I/O pin levels.
    input  wire logic [NUM_CELLS-1:0]   POLARITY_I,     // 1 inverts output.
    input  wire logic [2*NUM_CELLS-1:0] CLK_TERM_I,     // Clock terms.
    input  wire logic [2*NUM_CELLS-1:0] SUM_TERM_I,     // Sum-term data.
    output logic      [2*NUM_CELLS-1:0] REG_Q_O,        // Register feedback.
    output logic      [NUM_CELLS-1:0]   OUT_PIN_O,      // Output pin level.
    output logic                        RESET_BUSY_O    // Reset interval.
);

    // ======================================================================
    // Declarations.
    // ======================================================================
    rpr_state_t              state_reg;     // Sequencer state.
    rpr_state_t              state_next;    // Next sequencer state.
    logic [PR_CNT_W-1:0]     cnt_reg;       // Cycles spent in reset.
    logic [PR_CNT_W-1:0]     cnt_next;      // Next count.
    logic                    busy_reg;      // Reset interval flag.
    logic                    busy_next;     // Next reset interval flag.
    logic [2*NUM_CELLS-1:0]  term_reg;      // Clock terms one cycle ago.
    logic [2*NUM_CELLS-1:0]  strobe;        // Rising edges of clock terms.
    logic [NUM_CELLS-1:0]    out_reg;       // Registered output pins.
    logic [NUM_CELLS-1:0]    out_next;      // Next output pin levels.
    logic                    load_en;       // Loads allowed.

    // ======================================================================
    // Power-up reset sequencer.
    // ======================================================================
    // The interval is counted at its longest figure. Clock terms that move
    // during it are ignored rather than trusted, since the outside party is
    // expected to hold them still anyway.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        busy_next  = busy_reg;
        case (state_reg)
            ST_RESETTING: begin
                if (cnt_reg == PR_CNT_W'(PR_CYCLES - 1)) begin
                    state_next = ST_RUN;
                    busy_next  = 1'b0;
                end else begin
                    cnt_next = cnt_reg + PR_CNT_W'(1);
                end
            end
            ST_RUN: begin
                busy_next = 1'b0;
            end
            default: begin
                state_next = ST_RESETTING;
                cnt_next   = '0;
                busy_next  = 1'b1;
            end
        endcase
    end

    // Sequencer registers; reset restarts the interval.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state_reg <= ST_RESETTING;
            cnt_reg   <= '0;
            busy_reg  <= 1'b1;
        end else if (SYS_CE_I) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            busy_reg  <= busy_next;
        end
    end

    // Loads are blocked until the interval has ended.
    assign load_en = (state_reg == ST_RUN);

    // ======================================================================
    // Clock-term edge detection.
    // ======================================================================
    // A register acts on the rising edge of its clock term, so the term is
    // compared with its previous sample. Reset starts the history low to
    // match the idle level, and the history keeps sampling through the
    // interval, so a term held high across it gives no pulse afterwards.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            term_reg <= '0;
        end else if (SYS_CE_I) begin
            term_reg <= CLK_TERM_I;
        end
    end

    assign strobe = CLK_TERM_I & ~term_reg;

    // ======================================================================
    // Register cells.
    // ======================================================================
    for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
        rpr_cell u_cell (
            .clk_i      (SYS_CLK_I),
            .rst_i      (SYS_RST_I),
            .ce_i       (SYS_CE_I),
            .load_en_i  (load_en),
            .preload_i  (PRELOAD_HV_I),
            .select_i   (SELECT_I),
            .io_pin_i   (IO_PIN_I[c]),
            .strobe_i   (strobe[2*c +: 2]),
            .sum_term_i (SUM_TERM_I[2*c +: 2]),
            .q_o        (REG_Q_O[2*c +: 2])
        );
    end

    // ======================================================================
    // Output buffers.
    // ======================================================================
    // The first register of each cell drives its pin through the chosen
    // polarity; this costs one cycle of latency to keep the port on a flop.
    always_comb begin
        out_next = '0;
        for (int c = 0; c < NUM_CELLS; c++) begin
            out_next[c] = REG_Q_O[2*c + REG_FIRST] ^ POLARITY_I[c];
        end
    end

    // Output pin register.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            out_reg <= {NUM_CELLS{REG_RESET_VAL}};
        end else if (SYS_CE_I) begin
            out_reg <= out_next;
        end
    end

    assign OUT_PIN_O    = out_reg;
    assign RESET_BUSY_O = busy_reg;

    // ======================================================================
    // Assertions and covers; load, force and output checks watch cell 0.
    // ======================================================================
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_force_first_reg: assert property (
        SYS_CE_I && load_en && PRELOAD_HV_I && (|strobe[1:0]) && !SELECT_I
        |=> REG_Q_O[REG_FIRST] == $past(IO_PIN_I[0])
    ) else $error("Forced first register does not hold pin level.");

    a_force_second_reg: assert property (
        SYS_CE_I && load_en && PRELOAD_HV_I && (|strobe[1:0]) && SELECT_I
        |=> REG_Q_O[REG_SECOND] == $past(IO_PIN_I[0])
            && REG_Q_O[REG_FIRST] == $past(REG_Q_O[REG_FIRST])
    ) else $error("Forced second register wrong or first disturbed.");

    a_normal_load: assert property (
        SYS_CE_I && load_en && !PRELOAD_HV_I && strobe[REG_FIRST]
        |=> REG_Q_O[REG_FIRST] == $past(SUM_TERM_I[REG_FIRST])
    ) else $error("Normal load did not take the sum term.");

    a_reset_clears: assert property (disable iff (1'b0)
        SYS_RST_I |=> REG_Q_O == '0 && RESET_BUSY_O
    ) else $error("Reset did not clear registers.");

    a_reset_interval: assert property (
        $fell(RESET_BUSY_O) |-> $past(cnt_reg) == PR_CNT_W'(PR_CYCLES - 1)
    ) else $error("Reset interval has the wrong length.");

    a_busy_frozen: assert property (
        SYS_CE_I && RESET_BUSY_O |=> REG_Q_O == '0
    ) else $error("Register changed during the reset interval.");

    a_out_polarity: assert property (
        SYS_CE_I |=> OUT_PIN_O[0] == $past(REG_Q_O[REG_FIRST] ^ POLARITY_I[0])
    ) else $error("Output pin does not follow register and polarity.");

    c_force_first: cover property (
        load_en && PRELOAD_HV_I && strobe[0] && !SELECT_I);
    c_force_second: cover property (
        load_en && PRELOAD_HV_I && strobe[1] && SELECT_I);
    c_reset_done: cover property ($fell(RESET_BUSY_O));
    c_normal_load: cover property (load_en && !PRELOAD_HV_I && strobe[0]);

endmodule

// File: verification/rpr_preload_top_test.sv
`timescale 1ns/100ps
// ==========================================================================
// Bench: model of every register compared at each pulse.
// ==========================================================================
module rpr_preload_top_test
    import rpr_pkg::*;
;
    localparam int N = NUM_CELLS_DEF;  // Cells in the bench instance.
    logic           clk = 1'h0;        // System clock, 50 ns period.
    logic           rst;               // Synchronous reset, set at start.
    logic           ce = 1'h1;         // Clock enable.
    logic           hv_req = 1'h0;     // Force mode request.
    logic           sel = 1'h0;        // Force target register.
    logic           go = 1'h0;         // Pulse request to the tester.
    logic           busy;              // Reset interval flag.
    logic           mode;              // Mode level from the tester.
    logic [N-1:0]   pin = '0;          // Pin levels.
    logic [N-1:0]   pol = '0;          // Output polarity.
    logic [N-1:0]   outp;              // Output pins seen.
    logic [2*N-1:0] sum = '0;          // Sum-term data.
    logic [2*N-1:0] mask = '0;         // Terms to pulse.
    logic [2*N-1:0] term;              // Terms from the tester.
    logic [2*N-1:0] q;                 // Registers seen.
    logic [31:0]    seed = 32'h23B57508;  // Stimulus shift register.
    int             exp_q[2*N];        // Model of every register.
    int             failures = 0;      // Mismatches counted.
    int             tests_run = 0;     // Comparisons made.
    int             cycles = 0;        // Clock cycles since start.

    always #25 clk = ~clk;

    rpr_tester #(.N(N)) rpr_tester_inst (
        .busy_i(busy), .go_i(go), .hv_i(hv_req), .mask_i(mask),
        .mode_o(mode), .term_o(term));

    rpr_preload_top #(.NUM_CELLS(N)) rpr_preload_top_inst (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .SYS_CE_I(ce),
        .PRELOAD_HV_I(mode), .SELECT_I(sel), .IO_PIN_I(pin),
        .POLARITY_I(pol), .CLK_TERM_I(term), .SUM_TERM_I(sum),
        .REG_Q_O(q), .OUT_PIN_O(outp), .RESET_BUSY_O(busy));

    // Shift register for stimulus; its taps give a long cycle.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [2*N-1:0] exp_vec();
        logic [2*N-1:0] v;
        for (int b = 0; b < 2*N; b++) v[b] = exp_q[b][0];
        return v;
    endfunction

    // Callers pass the value seen first and the expected value second.
    task automatic check(input string nm, input logic [31:0] g,
                         input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // A hung wait is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            failures++;
            finish_test();
        end
    end

    // Reset, then time the busy flag; the interval may not exceed the
    // longest figure and all registers must read low afterwards.
    task automatic do_reset();
        int n;
        rst = 1'h1;
        repeat (16) @(negedge clk);
        rst = 1'h0;
        n = 0;
        while (busy === 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("busy_ok", 32'(n > 0 && n * CLK_PERIOD_NS <= PR_MAX_NS),
              32'h1);
        foreach (exp_q[b]) exp_q[b] = 0;
        check("reg_q_reset", 32'(q), 32'h0);
        check("out_reset", 32'(outp), 32'(pol));
        $display("test reset done");
    endtask

    // One pulse; the model follows the force or the normal path.
    task automatic pulse(input bit fm, input bit s, input bit en,
                         input logic [2*N-1:0] m);
        logic [N-1:0] o;
        seed = lfsr(seed);
        pin = seed[N-1:0];
        seed = lfsr(seed);
        sum = seed[2*N-1:0];
        if (en) pol = seed[31:32-N];
        hv_req = fm;
        sel = s;
        ce = en;
        mask = m;
        go = 1'h1;
        for (int b = 0; b < 2*N; b++) begin
            if (en && fm && (m[b & ~1] || m[b | 1]) && b % 2 == s)
                exp_q[b] = int'(pin[b / 2]);
            else if (en && !fm && m[b]) exp_q[b] = int'(sum[b]);
        end
        @(negedge clk);
        go = 1'h0;
        @(negedge clk);
        check("reg_q", 32'(q), 32'(exp_vec()));
        @(negedge clk);
        for (int c = 0; c < N; c++) o[c] = exp_q[2 * c][0] ^ pol[c];
        check("out_pin", 32'(outp), 32'(o));
    endtask

    // Main sequence: reset, force both targets from every term,
    // normal loads with random sum terms, frozen clock, second reset.
    initial begin
        do_reset();
        for (int i = 0; i < 40; i++) begin
            pulse(1'h1, 1'(i / 20), 1'h1, (2*N)'(1) << (i % 20));
        end
        $display("test force done");
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            pulse(1'h0, seed[3], 1'h1, seed[2*N+3:4]);
        end
        $display("test normal done");
        pulse(1'h1, 1'h0, 1'h0, '1);
        $display("test frozen done");
        pulse(1'h1, 1'h1, 1'h1, '1);
        do_reset();
        finish_test();
    end
endmodule

// File: verification/rpr_tester.sv
`timescale 1ns/100ps
// ==========================================================================
// Tester model: mode level and clock-term pulses.
// ==========================================================================
module rpr_tester
    import rpr_pkg::*;
#(
    parameter int N = NUM_CELLS_DEF  // Output cells driven.
)
(
    input  wire logic           busy_i,  // Reset interval running.
    input  wire logic           go_i,    // Bench asks for a pulse.
    input  wire logic           hv_i,    // Bench asks for force mode.
    input  wire logic [2*N-1:0] mask_i,  // Terms to pulse.
    output logic                mode_o,  // Elevated level detect.
    output logic      [2*N-1:0] term_o   // Clock terms to the device.
);
    // The elevated level reaches the device as a detect bit only.
    assign mode_o = hv_i;
    // Terms stay low while reset runs, so no register is clocked
    // before its clear has settled and setup has been met.
    assign term_o = (go_i && !busy_i) ? mask_i : '0;
endmodule
